// [core/sccs_ctrl.sv]
/*
  sccs_ctrl: control and status logic of the serial unit in smart card
  mode, with apb slave, event interrupt and clock pin control.
  assumes: datapath on core_clk gives tx_load / rx_done pulses; the
  baud clock arrives from another domain and is synchronised here.
*/
// The address map and the APB interface to the registers are this design's own decisions.
// Notes on behaviour
// - tx request only while tx irq enabled
// - rx and error requests need rx irq
// - transmitter works only with tx enable
// - receiver works only with rx enable
// - gating off: 00 pin free, 01 clock
// - gating on: 00 low, 10 high, x1 clock
// - clock selection changes take effect anytime
// - status flags ignore writes of one
// - status layout follows smart card select
// - tx empty set when disabled or loaded
// - tx empty cleared by write0 after read1
// - tx empty cleared by dma holding write
// - rx full set on clean reception
// - rx full cleared by write0 after read1
// - rx full cleared by dma holding read
// - rx disable leaves rx full unchanged
// - overrun set when receiving while full
`timescale 1ns/10ps
`default_nettype none
module sccs_ctrl (
  input  wire logic                 core_clk,         // 40 MHz
  input  wire logic                 rst_n,            // sync, low
  input  wire logic                 psel,             // apb select
  input  wire logic                 penable,          // apb access
  input  wire logic                 pwrite,           // apb direction
  input  wire logic [7:0]           paddr,            // byte address
  input  wire logic [31:0]          pwdata,           // write data
  output logic                      pready,           // apb ready
  output logic [31:0]               prdata,           // read data
  output logic                      pslverr,          // unmapped
  input  wire logic                 baud_clk,         // async bit clock
  input  wire logic                 tx_load,          // holding to shift
  input  wire logic                 tx_busy,          // shifter busy
  input  wire logic                 rx_done,          // reception ends
  input  wire sccs_pkg::sccs_rxword_t rx_word,        // with rx_done
  input  wire logic                 dtc_tx_wr,        // dma writes hold
  input  wire logic [7:0]           dtc_tx_data,      // dma data
  input  wire logic                 dtc_rx_rd,        // dma reads hold
  output logic [7:0]                tx_holding,       // to shifter
  output logic [7:0]                rx_holding,       // to dma
  output logic                      tx_run,           // tx may work
  output logic                      rx_run,           // rx may work
  output logic                      tx_empty_request, // to cpu / dma
  output logic                      rx_full_request,  // to cpu / dma
  output logic                      rx_error_request, // to cpu
  output logic                      irq,              // level interrupt
  output logic                      sck_o,            // clock pin level
  output logic                      sck_oe_n          // low: driving
);

  sccs_pkg::sccs_ctrl_t ctrl_q;           // serial_control
  logic [1:0]           mode_q;           // gating mode, card select
  logic [7:0]           tx_hold_q;        // tx_holding_reg
  logic [7:0]           rx_hold_q;        // rx_holding_reg
  logic                 tx_holding_empty_q, rx_holding_full_q;   // holding flags
  logic                 overrun_flag_q, per_q;    // error flags
  logic                 fer_q;            // framing / error signal
  logic [4:0]           armed_q;          // flags seen at one
  logic [sccs_pkg::EV_W-1:0] ev_stat_q;   // sticky events
  logic [sccs_pkg::EV_W-1:0] ev_mask_q;   // event mask
  logic                 pready_q, pslverr_q;
  logic [31:0]          prdata_q;
  logic                 txr_q, rxr_q, ter_q, rfr_q, rer_q, irq_q;
  logic                 bclk_s1_q, bclk_s2_q; // synchroniser
  logic                 sck_q, sck_oe_n_q;

  // bus decode, taken at the completing access edge
  logic       acc, wr, rd;
  logic [7:0] wbyte;
  logic [7:0] status_view;
  logic       mapped;
  assign acc   = psel & penable & pready_q;
  assign wr    = acc & pwrite;
  assign rd    = acc & ~pwrite;
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    mapped = 1'b1;
    case (paddr)
      sccs_pkg::OFS_CTRL, sccs_pkg::OFS_STATUS, sccs_pkg::OFS_MODE,
      sccs_pkg::OFS_TXDATA, sccs_pkg::OFS_RXDATA,
      sccs_pkg::OFS_IRQ_STAT, sccs_pkg::OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // status view: bit 4 means framing error normally, error signal
  // in card mode, where the parity flag is also ORed into it
  always_comb
  begin
    status_view = 8'h00;
    status_view[sccs_pkg::ST_TX_HOLDING_EMPTY] = tx_holding_empty_q;
    status_view[sccs_pkg::ST_RX_HOLDING_FULL] = rx_holding_full_q;
    status_view[sccs_pkg::ST_OVERRUN_FLAG] = overrun_flag_q;
    status_view[sccs_pkg::ST_PER]  = per_q;
    if (mode_q[sccs_pkg::MD_SMART_CARD_SELECT])
    begin
      // card mode: bit 4 reports the error signal, bit 2 end of tx
      status_view[sccs_pkg::ST_FER]  = fer_q | per_q;
      status_view[sccs_pkg::ST_TEND] = tx_holding_empty_q & ~tx_busy;
    end
    else
    begin
      status_view[sccs_pkg::ST_FER]  = fer_q;
      status_view[sccs_pkg::ST_TEND] = tx_holding_empty_q & ~tx_busy;
    end
  end

  // apb handshake: ready rises for the first access cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= sccs_pkg::RD_ZERO;
    end
    else
    begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
      begin
        // read data captured at setup; unmapped reads as zero
        case (paddr)
          sccs_pkg::OFS_CTRL:     prdata_q <= {24'h000000, ctrl_q};
          sccs_pkg::OFS_STATUS:   prdata_q <= {24'h000000, status_view};
          sccs_pkg::OFS_MODE:     prdata_q <= {30'h0, mode_q};
          sccs_pkg::OFS_TXDATA:   prdata_q <= {24'h000000, tx_hold_q};
          sccs_pkg::OFS_RXDATA:   prdata_q <= {24'h000000, rx_hold_q};
          sccs_pkg::OFS_IRQ_STAT: prdata_q <= {29'h0, ev_stat_q};
          sccs_pkg::OFS_IRQ_MASK: prdata_q <= {29'h0, ev_mask_q};
          default:                prdata_q <= sccs_pkg::RD_ZERO;
        endcase
      end
      else if (acc)
        prdata_q <= sccs_pkg::RD_ZERO;
    end
  end

  // control and mode registers; the two unused enables are stored
  // as written, software keeps them zero in card mode
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl_q <= sccs_pkg::CTRL_RST;
      mode_q <= sccs_pkg::MODE_RST[1:0];
    end
    else if (wr && paddr == sccs_pkg::OFS_CTRL)
      ctrl_q <= wbyte;
    else if (wr && paddr == sccs_pkg::OFS_MODE)
      mode_q <= wbyte[1:0];
  end

  // holding registers; dma write counts only when it was requested
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      tx_hold_q <= 8'h00;
    else if (dtc_tx_wr && ter_q)
      tx_hold_q <= dtc_tx_data;
    else if (wr && paddr == sccs_pkg::OFS_TXDATA)
      tx_hold_q <= wbyte;
  end

  // clean reception while empty loads the holding register
  logic rx_ok, rx_clean, rx_over;
  assign rx_ok    = rx_done & ctrl_q.rx_enable;
  assign rx_clean = rx_ok & ~rx_word.perr & ~rx_word.ferr & ~rx_holding_full_q;
  assign rx_over  = rx_ok & rx_holding_full_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rx_hold_q <= 8'h00;
    else if (rx_clean)
      rx_hold_q <= rx_word.data;
  end

  // read-then-write-zero: a flag seen at one by a status read arms
  // its clear; any status write disarms so a stale read cannot clear
  logic st_wr;
  logic [4:0] flags_now;
  assign st_wr     = wr && paddr == sccs_pkg::OFS_STATUS;
  assign flags_now = {tx_holding_empty_q, rx_holding_full_q, overrun_flag_q, per_q, fer_q};

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      armed_q <= 5'h00;
    else if (rd && paddr == sccs_pkg::OFS_STATUS)
      armed_q <= flags_now;
    else if (st_wr)
      armed_q <= 5'h00;
  end

  // writes of one are ignored: only an armed zero clears
  logic clr_tx_holding_empty, clr_rx_holding_full, clr_overrun_flag, clr_per, clr_fer;
  assign clr_tx_holding_empty = st_wr & ~wbyte[sccs_pkg::ST_TX_HOLDING_EMPTY] & armed_q[4];
  assign clr_rx_holding_full = st_wr & ~wbyte[sccs_pkg::ST_RX_HOLDING_FULL] & armed_q[3];
  assign clr_overrun_flag = st_wr & ~wbyte[sccs_pkg::ST_OVERRUN_FLAG] & armed_q[2];
  assign clr_per  = st_wr & ~wbyte[sccs_pkg::ST_PER]  & armed_q[1];
  assign clr_fer  = st_wr & ~wbyte[sccs_pkg::ST_FER]  & armed_q[0];

  // transmit empty: set wins over every clear
  logic tx_holding_empty_set;
  assign tx_holding_empty_set = ~ctrl_q.tx_enable | (tx_load & ctrl_q.tx_enable);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      tx_holding_empty_q <= sccs_pkg::TX_HOLDING_EMPTY_RST;
    else if (tx_holding_empty_set)
      tx_holding_empty_q <= 1'b1;
    else if (clr_tx_holding_empty)
      tx_holding_empty_q <= 1'b0;
    else if (dtc_tx_wr && ter_q)
      tx_holding_empty_q <= 1'b0;
  end

  // receive full: rx enable has no say in its clearing
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rx_holding_full_q <= 1'b0;
    else if (rx_clean)
      rx_holding_full_q <= 1'b1;
    else if (clr_rx_holding_full)
      rx_holding_full_q <= 1'b0;
    else if (dtc_rx_rd && rfr_q)
      rx_holding_full_q <= 1'b0;
  end

  // error flags
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      overrun_flag_q <= 1'b0;
      per_q  <= 1'b0;
      fer_q  <= 1'b0;
    end
    else
    begin
      if (rx_over)
        overrun_flag_q <= 1'b1;
      else if (clr_overrun_flag)
        overrun_flag_q <= 1'b0;
      if (rx_ok && rx_word.perr)
        per_q <= 1'b1;
      else if (clr_per)
        per_q <= 1'b0;
      if (rx_ok && rx_word.ferr)
        fer_q <= 1'b1;
      else if (clr_fer)
        fer_q <= 1'b0;
    end
  end

  // requests and run levels, all registered
  logic err_any;
  assign err_any = overrun_flag_q | per_q | fer_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ter_q <= 1'b0;
      rfr_q <= 1'b0;
      rer_q <= 1'b0;
      txr_q <= 1'b0;
      rxr_q <= 1'b0;
    end
    else
    begin
      ter_q <= tx_holding_empty_q & ctrl_q.tx_irq_enable;
      rfr_q <= rx_holding_full_q & ctrl_q.rx_irq_enable;
      rer_q <= err_any & ctrl_q.rx_irq_enable;
      txr_q <= ctrl_q.tx_enable;
      rxr_q <= ctrl_q.rx_enable;
    end
  end

  // sticky events: set wins over the write-one clear
  logic [sccs_pkg::EV_W-1:0] ev_set;
  logic                      tx_holding_empty_d1_q, rx_holding_full_d1_q, err_d1_q;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tx_holding_empty_d1_q <= sccs_pkg::TX_HOLDING_EMPTY_RST;
      rx_holding_full_d1_q <= 1'b0;
      err_d1_q  <= 1'b0;
    end
    else
    begin
      tx_holding_empty_d1_q <= tx_holding_empty_q;
      rx_holding_full_d1_q <= rx_holding_full_q;
      err_d1_q  <= err_any;
    end
  end

  always_comb
  begin
    ev_set = '0;
    ev_set[sccs_pkg::EV_TX]  = tx_holding_empty_q & ~tx_holding_empty_d1_q;
    ev_set[sccs_pkg::EV_RX]  = rx_holding_full_q & ~rx_holding_full_d1_q;
    ev_set[sccs_pkg::EV_ERR] = err_any & ~err_d1_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ev_stat_q <= '0;
      ev_mask_q <= '0;
      irq_q     <= 1'b0;
    end
    else
    begin
      if (wr && paddr == sccs_pkg::OFS_IRQ_STAT)
        ev_stat_q <= (ev_stat_q & ~wbyte[sccs_pkg::EV_W-1:0]) | ev_set;
      else
        ev_stat_q <= ev_stat_q | ev_set;
      if (wr && paddr == sccs_pkg::OFS_IRQ_MASK)
        ev_mask_q <= wbyte[sccs_pkg::EV_W-1:0];
      irq_q <= |(ev_stat_q & ev_mask_q);
    end
  end

  // baud clock synchroniser; only the second stage is read
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
    end
    else
    begin
      bclk_s1_q <= baud_clk;
      bclk_s2_q <= bclk_s1_q;
    end
  end

  // clock pin; selection is decoded live, so a change takes hold on
  // the next edge, but glitch-free switching is left to software
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sck_q      <= 1'b0;
      sck_oe_n_q <= 1'b1;
    end
    else if (mode_q[sccs_pkg::MD_GM])
    begin
      sck_oe_n_q <= 1'b0;
      if (ctrl_q.clk_out_sel[0])
        sck_q <= bclk_s2_q;
      else
        sck_q <= (ctrl_q.clk_out_sel == sccs_pkg::CKE_HIGH);
    end
    else
    begin
      // reserved codes 1X keep the pin free
      sck_oe_n_q <= ~(ctrl_q.clk_out_sel == sccs_pkg::CKE_CLK);
      sck_q      <= (ctrl_q.clk_out_sel == sccs_pkg::CKE_CLK) & bclk_s2_q;
    end
  end

  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign prdata           = prdata_q;
  assign tx_holding       = tx_hold_q;
  assign rx_holding       = rx_hold_q;
  assign tx_run           = txr_q;
  assign rx_run           = rxr_q;
  assign tx_empty_request = ter_q;
  assign rx_full_request  = rfr_q;
  assign rx_error_request = rer_q;
  assign irq              = irq_q;
  assign sck_o            = sck_q;
  assign sck_oe_n         = sck_oe_n_q;

  // checks
  sequence s_rd_one(int b);
    rd && paddr == sccs_pkg::OFS_STATUS && status_view[b];
  endsequence
  sequence s_wr_zero(int b);
    wr && paddr == sccs_pkg::OFS_STATUS && !wbyte[b];
  endsequence

  a_tx_req_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    tx_empty_request |-> $past(ctrl_q.tx_irq_enable))
    else $error("tx request without enable");
  a_rx_req_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rx_full_request || rx_error_request)
      |-> $past(ctrl_q.rx_irq_enable))
    else $error("rx request without enable");
  a_req_product: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 tx_empty_request == $past(tx_holding_empty_q & ctrl_q.tx_irq_enable))
    else $error("tx request not flag and enable");
  a_tx_holding_empty_set_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    !ctrl_q.tx_enable |=> tx_holding_empty_q)
    else $error("tx empty not set while disabled");
  a_tx_holding_empty_rd_clr: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_rd_one(sccs_pkg::ST_TX_HOLDING_EMPTY) ##[2:3] s_wr_zero(sccs_pkg::ST_TX_HOLDING_EMPTY)
      ##0 !tx_holding_empty_set |=> !tx_holding_empty_q)
    else $error("tx empty not cleared after read one");
  a_rx_holding_full_clean: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_done && ctrl_q.rx_enable && !rx_holding_full_q && !rx_word.perr
      && !rx_word.ferr |=> rx_holding_full_q && rx_hold_q == $past(rx_word.data))
    else $error("clean reception not stored");
  a_rx_holding_full_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(ctrl_q.rx_enable) && !$past(rx_clean) && !$past(dtc_rx_rd)
      && !dtc_rx_rd |-> $stable(rx_holding_full_q) ##1 $stable(rx_holding_full_q))
    else $error("rx full changed by rx disable");
  a_overrun_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    rx_done && ctrl_q.rx_enable && rx_holding_full_q |=> overrun_flag_q && rx_holding_full_q)
    else $error("overrun not flagged");
  a_one_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_wr && wbyte[sccs_pkg::ST_RX_HOLDING_FULL] && !rx_holding_full_q && !rx_clean
      |=> !rx_holding_full_q)
    else $error("write of one set rx full");
  a_sck_fixed: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_q[sccs_pkg::MD_GM] && ctrl_q.clk_out_sel == sccs_pkg::CKE_OFF
      |=> !sck_o && !sck_oe_n)
    else $error("clock pin not fixed low");
  a_sck_free: assert property (@(posedge core_clk) disable iff (!rst_n)
    !mode_q[sccs_pkg::MD_GM] && ctrl_q.clk_out_sel != sccs_pkg::CKE_CLK
      |=> sck_oe_n)
    else $error("clock pin driven while off");
  a_tx_run: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(ctrl_q.tx_enable) |=> tx_run ##0 $past(tx_holding_empty_q))
    else $error("tx run not following enable");

endmodule // sccs_ctrl
`default_nettype wire

// [core/sccs_pkg.sv]
/*
  sccs_pkg: register map, field layout, reset values and carrier types
  of the smart card serial control and status block.
  assumes: 32-bit apb with byte addresses, 8-bit registers in low bits.
*/
`default_nettype none
package sccs_pkg;
  // register byte addresses
  localparam logic [7:0] OFS_CTRL     = 8'h00; // serial_control
  localparam logic [7:0] OFS_STATUS   = 8'h04; // serial_status
  localparam logic [7:0] OFS_MODE     = 8'h08; // gating mode, card select
  localparam logic [7:0] OFS_TXDATA   = 8'h0C; // tx_holding_reg
  localparam logic [7:0] OFS_RXDATA   = 8'h10; // rx_holding_reg
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14; // sticky events, w1c
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18; // event mask
  // status bit positions
  localparam int ST_TX_HOLDING_EMPTY = 7;  // tx_holding_empty
  localparam int ST_RX_HOLDING_FULL = 6;  // rx_holding_full
  localparam int ST_OVERRUN_FLAG = 5;  // overrun_flag
  localparam int ST_FER  = 4;  // framing (normal) / error signal (card)
  localparam int ST_PER  = 3;  // parity_err_flag
  localparam int ST_TEND = 2;  // transmit end, read only
  // mode register bit positions
  localparam int MD_GM   = 0;  // clock_gating_mode
  localparam int MD_SMART_CARD_SELECT = 1;  // smart_card_select
  // event bit positions
  localparam int EV_TX  = 0;   // transmit holding became empty
  localparam int EV_RX  = 1;   // receive holding became full
  localparam int EV_ERR = 2;   // a receive error flag was set
  localparam int EV_W   = 3;   // number of events
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic       TX_HOLDING_EMPTY_RST = 1'b1;
  // clock enable field codes
  localparam logic [1:0] CKE_OFF  = 2'h0; // off / fixed low
  localparam logic [1:0] CKE_HIGH = 2'h2; // fixed high under gating
  localparam logic [1:0] CKE_CLK  = 2'h1; // clock output, both modes
  // apb
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // serial_control layout, bit 7 first
  typedef struct packed {
    logic       tx_irq_enable;        // bit 7
    logic       rx_irq_enable;        // bit 6
    logic       tx_enable;            // bit 5
    logic       rx_enable;            // bit 4
    logic       multiproc_irq_enable; // bit 3
    logic       tx_end_irq_enable;    // bit 2
    logic [1:0] clk_out_sel;          // bits 1:0, hi then lo
  } sccs_ctrl_t;

  // received character with its error marks
  typedef struct packed {
    logic [7:0] data;  // character from rx_shift_reg
    logic       perr;  // parity error seen
    logic       ferr;  // framing / error signal seen
  } sccs_rxword_t;
endpackage : sccs_pkg
`default_nettype wire

// [testbench/sccs_card.sv]
/*
  sccs_card: behavioural smart card seen from the clock pin only.
  assumes: pin has a pull-up on the card side; core_clk is fast
  enough to see every level change of the card clock.
*/
`timescale 1ns/10ps
`default_nettype none
module sccs_card (
  input  wire logic        core_clk,   // sampling clock of the bench
  input  wire logic        sck_o,      // level the block drives
  input  wire logic        sck_oe_n,   // low while the block drives
  input  wire logic        clr,        // restart the edge count
  output logic             card_level, // level seen at the card
  output logic [15:0]      card_edges  // pin changes since clr
);
  logic last_q; // pin level one sample ago

  // released pin goes high through the pull-up, never holds a value
  assign card_level = sck_oe_n ? 1'b1 : sck_o;

  // card counts clock transitions; a fixed level gives none
  always_ff @(posedge core_clk)
  begin
    last_q <= card_level;
    if (clr)
      card_edges <= 16'h0000;
    else if (card_level != last_q)
      card_edges <= card_edges + 16'h0001;
  end
endmodule // sccs_card
`default_nettype wire

// [testbench/tb.sv]
/*
  tb: register level tests of sccs_ctrl over apb, with datapath pulses
  and a card model on the clock pin.
  assumes: sccs_pkg and sccs_ctrl compiled first; tx_busy held low.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        core_clk, rst_n, psel, penable, pwrite, baud_clk;
  logic        tx_load, tx_busy, rx_done, dtc_tx_wr, dtc_rx_rd, clr;
  logic [7:0]  paddr, dtc_tx_data, tx_holding, rx_holding;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, tx_run, rx_run, irq, sck_o, sck_oe_n;
  logic        tx_empty_request, rx_full_request, rx_error_request;
  logic        card_level, gm, run;
  logic [15:0] card_edges;
  logic [1:0]  cke;
  sccs_pkg::sccs_rxword_t rx_word;
  int          num_errors, comparisons, i;

  // 40 MHz core clock, 200 ns link clock, its edges on falling core_clk edges
  always #12.5 core_clk = ~core_clk;
  always #100 baud_clk = ~baud_clk;

  sccs_ctrl i_sccs_ctrl (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .baud_clk(baud_clk), .tx_load(tx_load), .tx_busy(tx_busy),
    .rx_done(rx_done), .rx_word(rx_word), .dtc_tx_wr(dtc_tx_wr),
    .dtc_tx_data(dtc_tx_data), .dtc_rx_rd(dtc_rx_rd),
    .tx_holding(tx_holding), .rx_holding(rx_holding), .tx_run(tx_run),
    .rx_run(rx_run), .tx_empty_request(tx_empty_request),
    .rx_full_request(rx_full_request), .rx_error_request(rx_error_request),
    .irq(irq), .sck_o(sck_o), .sck_oe_n(sck_oe_n));

  sccs_card i_sccs_card (.core_clk(core_clk), .sck_o(sck_o),
    .sck_oe_n(sck_oe_n), .clr(clr), .card_level(card_level),
    .card_edges(card_edges));

  // one compare for every kind of value
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // apb transfer; waits for pready as long as it takes, only the
  // watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rdv);
  endtask

  // one-cycle strobe: 0 load shifter, 1 dma write, 2 dma read
  task automatic strobe(input int k);
    @(posedge core_clk);
    tx_load <= (k == 0);
    dtc_tx_wr <= (k == 1);
    dtc_rx_rd <= (k == 2);
    @(posedge core_clk);
    {tx_load, dtc_tx_wr, dtc_rx_rd} <= 3'h0;
    idle(4);
  endtask

  // reception end with its word and error mark
  task automatic rx(input logic [7:0] dat, input logic pe);
    @(posedge core_clk);
    rx_done <= 1'b1;
    rx_word <= {dat, pe, 1'b0};
    @(posedge core_clk);
    rx_done <= 1'b0;
    idle(4);
  endtask

  task stop_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, well beyond the under one thousand cycles the tests need
  initial
  begin
    #200000;
    num_errors++;
    stop_test;
  end

  initial
  begin
    {core_clk, baud_clk, psel, penable, pwrite, tx_load, clr} = 7'h00;
    {tx_busy, rx_done, dtc_tx_wr, dtc_rx_rd, rst_n} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_word = 10'h000;
    dtc_tx_data = 8'h5A;
    idle(16);
    rst_n <= 1'b1;
    // reset values and refusals
    chk("tx_req", 1'b0, tx_empty_request);
    chk("sck_oe_n", 1'b1, sck_oe_n);
    rdc(sccs_pkg::OFS_CTRL, 32'h0);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    rdc(8'h1C, 32'h0);
    chk("pslverr", 1'b1, pslverr);
    wr(sccs_pkg::OFS_STATUS, 32'hFF);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    wr(sccs_pkg::OFS_MODE, 32'h02);
    // transmit empty flag: clear, disarm, dma and enable paths
    wr(sccs_pkg::OFS_CTRL, 32'h20);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    wr(sccs_pkg::OFS_STATUS, 32'h00);
    rdc(sccs_pkg::OFS_STATUS, 32'h00);
    chk("tx_run", 1'b1, tx_run);
    strobe(0);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    wr(sccs_pkg::OFS_STATUS, 32'h80);
    wr(sccs_pkg::OFS_STATUS, 32'h00);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    wr(sccs_pkg::OFS_STATUS, 32'h00);
    wr(sccs_pkg::OFS_CTRL, 32'hA0);
    idle(3);
    chk("tx_req", 1'b0, tx_empty_request);
    strobe(0);
    chk("tx_req", 1'b1, tx_empty_request);
    strobe(1);
    chk("tx_req", 1'b0, tx_empty_request);
    chk("tx_holding", 8'h5A, tx_holding);
    rdc(sccs_pkg::OFS_TXDATA, 32'h5A);
    rdc(sccs_pkg::OFS_STATUS, 32'h00);
    wr(sccs_pkg::OFS_CTRL, 32'h00);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    chk("tx_run", 1'b0, tx_run);
    // receive side: disabled, full, overrun, dma, errors
    rx(8'h11, 1'b0);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    chk("rx_run", 1'b0, rx_run);
    wr(sccs_pkg::OFS_CTRL, 32'h50);
    rx(8'hA5, 1'b0);
    chk("rx_run", 1'b1, rx_run);
    rdc(sccs_pkg::OFS_STATUS, 32'hC4);
    chk("rx_holding", 8'hA5, rx_holding);
    rdc(sccs_pkg::OFS_RXDATA, 32'hA5);
    chk("rx_req", 1'b1, rx_full_request);
    rx(8'h3C, 1'b0);
    rdc(sccs_pkg::OFS_STATUS, 32'hE4);
    chk("rx_holding", 8'hA5, rx_holding);
    wr(sccs_pkg::OFS_CTRL, 32'h40);
    idle(2);
    rdc(sccs_pkg::OFS_STATUS, 32'hE4);
    wr(sccs_pkg::OFS_STATUS, 32'hDF);
    rdc(sccs_pkg::OFS_STATUS, 32'hC4);
    strobe(2);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    wr(sccs_pkg::OFS_CTRL, 32'h50);
    rx(8'h00, 1'b1);
    rdc(sccs_pkg::OFS_STATUS, 32'h9C);
    chk("rx_err_req", 1'b1, rx_error_request);
    wr(sccs_pkg::OFS_MODE, 32'h00);
    rdc(sccs_pkg::OFS_STATUS, 32'h8C);
    wr(sccs_pkg::OFS_MODE, 32'h02);
    wr(sccs_pkg::OFS_CTRL, 32'h10);
    idle(3);
    chk("rx_err_req", 1'b0, rx_error_request);
    rdc(sccs_pkg::OFS_STATUS, 32'h9C);
    wr(sccs_pkg::OFS_STATUS, 32'h80);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    // sticky event, mask and level interrupt
    wr(sccs_pkg::OFS_IRQ_STAT, 32'h07);
    wr(sccs_pkg::OFS_IRQ_MASK, 32'h02);
    rx(8'h77, 1'b0);
    chk("irq", 1'b1, irq);
    rdc(sccs_pkg::OFS_IRQ_STAT, 32'h02);
    rdc(sccs_pkg::OFS_STATUS, 32'hC4);
    wr(sccs_pkg::OFS_STATUS, 32'h80);
    rdc(sccs_pkg::OFS_STATUS, 32'h84);
    wr(sccs_pkg::OFS_IRQ_STAT, 32'h02);
    idle(3);
    chk("irq", 1'b0, irq);
    wr(sccs_pkg::OFS_IRQ_MASK, 32'h00);
    rx(8'h78, 1'b0);
    chk("irq", 1'b0, irq);
    wr(sccs_pkg::OFS_IRQ_MASK, 32'h02);
    idle(3);
    chk("irq", 1'b1, irq);
    // every gating mode and clock select, switched while running
    for (i = 0; i < 8; i++)
    begin
      gm = i[2];
      cke = i[1:0];
      wr(sccs_pkg::OFS_MODE, {30'h0, 1'b1, gm});
      wr(sccs_pkg::OFS_CTRL, {30'h0, cke});
      idle(6);
      clr <= 1'b1;
      idle(1);
      clr <= 1'b0;
      idle(40);
      run = cke[0] && (gm || !cke[1]);
      chk("sck_oe_n", !(gm || cke == 2'h1), sck_oe_n);
      chk("sck_edges", run, card_edges != 16'h0000);
      if (gm && !cke[0])
        chk("sck_level", cke[1], card_level);
    end
    stop_test;
  end
endmodule // tb
`default_nettype wire
